/* logic/hcis_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the hub
  stage interlock and event status bank.
  Assumes it is included by bare name from the design file; the package does not include it.
*/
`ifndef HCIS_REGS_SVH
`define HCIS_REGS_SVH

// ==========================================================================
// Register offsets on the serial-port register address space.
`define HCIS_OFS_ILOCK        8'hE7
`define HCIS_OFS_STATUS       8'hE8

// ==========================================================================
// Interlock register fields, reset value and writable-bit mask.
`define HCIS_ILOCK_RESET      8'h32
`define HCIS_ILOCK_WMASK      8'h33
`define HCIS_BIT_OC_SEL       5
`define HCIS_BIT_PWR_SEL      4
`define HCIS_BIT_CONNECT_N    1
`define HCIS_BIT_CONFIG_N     0

// ==========================================================================
// Status register fields: pin-active bit and the lowest event flag bit.
`define HCIS_BIT_INT_ACTIVE   7
`define HCIS_BIT_FLAG_LSB     2
`define HCIS_NUM_FLAGS        3

// ==========================================================================
// Configuration timeout for setup_timeout_field value 00, and clock rate.
`define HCIS_SETUP_TIMEOUT_US 95000
`define HCIS_CLK_MHZ          50
`define HCIS_SETUP_TIMEOUT_CYC (`HCIS_SETUP_TIMEOUT_US * `HCIS_CLK_MHZ)

`endif

/* logic/hcis_pkg.sv */
/*
  Types shared by the hub stage interlock and event status bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hcis_pkg;

  // ========================================================================
  // Hub operating stage, one-hot.
  typedef enum logic [2:0] {
    HCIS_ST_CONFIG  = 3'b001,  // Configuration stage, serial writes accepted.
    HCIS_ST_CONNECT = 3'b010,  // Connect stage, upstream attach held off.
    HCIS_ST_COMM    = 3'b100   // Communication stage, normal operation.
  } hcis_stage_e;

endpackage

/* logic/hcis_sync3.sv */
/*
  Three-stage synchroniser with a settle filter for one asynchronous pin.
  Assumes the pin level may change at any time relative to clk.
*/
module hcis_sync3 #(
  parameter logic IDLE_LEVEL = 1'b1  // Level assumed before the pin is seen.
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pin_async,
  output logic      pin_level
);

  // ========================================================================
  // Stage flops; the first is read only by the second to limit metastability.
  logic [2:0] stage;       // Shift chain, bit 0 nearest the pin.
  logic [2:0] next_stage;  // Next chain value.
  logic       next_level;  // Next filtered level.

  // The accepted level only moves once the second and third stages agree.
  always_comb begin
    next_stage = {stage[1:0], pin_async};
    next_level = (stage[1] == stage[2]) ? stage[2] : pin_level;
  end

  // Registers only; reset takes the idle constant.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage     <= {3{IDLE_LEVEL}};
      pin_level <= IDLE_LEVEL;
    end else begin
      stage     <= next_stage;
      pin_level <= next_level;
    end
  end

endmodule

/* logic/hcis_top.sv */
/*
  Hub stage interlock and event interrupt status registers, with the stage
  sequencer, pin role selection and interrupt pin latch.
  Assumes a serial-port engine on the same clock that presents one-cycle
  register read and write strobes, a hub core that pulses its events, and an
  interrupt mask register held elsewhere whose enables arrive as levels.
  // How it works
  // RULE_01 - Interlock resets to 0x32.
  // RULE_02 - Bit 5 selects pin or register over-current.
  // RULE_03 - Bit 4 enables active-high power switch pin.
  // RULE_04 - Bit 1 set holds connect stage.
  // RULE_05 - Bit 1 clear advances to communication stage.
  // RULE_06 - Bit 0 set holds configuration stage.
  // RULE_07 - Writing bit 0 low exits configuration immediately.
  // RULE_08 - Untouched default exits configuration after timeout.
  // RULE_09 - Processor writes interlock first, within timeout.
  // RULE_10 - Processor clears bit 0 when configured.
  // RULE_11 - Status bit 7 mirrors interrupt pin asserted.
  // RULE_12 - Writing zero to bit 7 releases pin.
  // RULE_13 - Suspend flag sticky, cleared by zero write.
  // RULE_14 - Host setup flag sticky, cleared by zero.
  // RULE_15 - Power update flag sticky, cleared by zero.
  // RULE_16 - Only enabled events pull interrupt pin low.
  // RULE_17 - Configuration timeout is 95 ms.
  // RULE_18 - Reserved bits read zero, ignore writes.
*/
`include "hcis_regs.svh"

module hcis_top
  import hcis_pkg::*;
#(
  parameter int unsigned SETUP_TIMEOUT_CYC = `HCIS_SETUP_TIMEOUT_CYC  // RULE_17
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       suspend_event,
  input  wire logic       host_setup_event,
  input  wire logic       power_update_event,
  input  wire logic       suspend_event_enable,
  input  wire logic       host_setup_event_enable,
  input  wire logic       power_update_event_enable,
  input  wire logic       overcurrent_pin_n,
  input  wire logic       overcurrent_reg,
  output logic            overcurrent_flag,
  input  wire logic       port_power_req,
  output logic            port_power_pin,
  output logic            port_power_pin_oe,
  output logic            int_n,
  output logic            stage_config,
  output logic            stage_connect,
  output logic            stage_comm
);

  // ========================================================================
  // Decoding helpers.

  // True when a strobe addresses the given register offset.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // ========================================================================
  // Declarations.
  localparam int unsigned NF = `HCIS_NUM_FLAGS;  // Number of event flags.

  logic [7:0]    ilock;            // Interlock register, writable bits only.
  logic [7:0]    next_ilock;       // Next interlock value.
  logic [NF-1:0] flag;             // Sticky event flags, bit 0 = power update.
  logic [NF-1:0] next_flag;        // Next flag values.
  logic [NF-1:0] evt;              // Event pulses in flag order.
  logic [NF-1:0] evt_en;           // Enables in flag order.
  logic          int_active;       // Interrupt pin asserted latch.
  logic          next_int_active;  // Next latch value.
  hcis_stage_e   stage;            // Current hub stage.
  hcis_stage_e   next_stage;       // Next hub stage.
  logic          touched;          // Processor wrote the interlock in time.
  logic          next_touched;     // Next touched value.
  logic [22:0]   tmr;              // Configuration stage cycle counter.
  logic [22:0]   next_tmr;         // Next counter value.
  logic [7:0]    next_rdata;       // Next read data.
  logic          wr_ilock;         // Write strobe to the interlock register.
  logic          wr_stat;          // Write strobe to the status register.
  logic          oc_level;         // Settled over-current pin level.
  logic          tmr_done;         // Timeout reached in this cycle.

  assign evt    = {suspend_event, host_setup_event, power_update_event};
  assign evt_en = {suspend_event_enable, host_setup_event_enable,
                   power_update_event_enable};

  // ========================================================================
  // Register strobes and pin roles.

  // The over-current pin comes from another domain, so it is synchronised.
  hcis_sync3 #(
    .IDLE_LEVEL (1'b1)
  ) u_oc_sync (
    .clk       (clk),
    .nrst      (nrst),
    .pin_async (overcurrent_pin_n),
    .pin_level (oc_level)
  );

  always_comb begin
    wr_ilock = reg_wr && reg_hit(reg_addr, `HCIS_OFS_ILOCK);
    wr_stat  = reg_wr && reg_hit(reg_addr, `HCIS_OFS_STATUS);
    tmr_done = (tmr == 23'(SETUP_TIMEOUT_CYC - 1));
    // Pin is active low when selected; otherwise register bits report.
    overcurrent_flag  = ilock[`HCIS_BIT_OC_SEL] ? !oc_level  // RULE_02
                                                : overcurrent_reg;
    // Pin disabled (not driven) when register control is chosen.
    port_power_pin_oe = ilock[`HCIS_BIT_PWR_SEL];  // RULE_03
    port_power_pin    = ilock[`HCIS_BIT_PWR_SEL] && port_power_req;  // RULE_03
    int_n             = !int_active;  // RULE_11
    stage_config      = (stage == HCIS_ST_CONFIG);
    stage_connect     = (stage == HCIS_ST_CONNECT);
    stage_comm        = (stage == HCIS_ST_COMM);
  end

  // ========================================================================
  // Interlock register: reserved bits are masked off on every write.
  always_comb begin
    next_ilock = ilock;
    if (wr_ilock) begin
      next_ilock = reg_wdata & `HCIS_ILOCK_WMASK;  // RULE_18
    end
  end

  // ========================================================================
  // Event flags. A new event wins over a clearing write in the same cycle,
  // so no event is ever lost to a racing software clear.
  generate
    for (genvar i = 0; i < NF; i++) begin : g_flag
      assign next_flag[i] = evt[i] ||  // RULE_13 RULE_14 RULE_15
        (flag[i] && !(wr_stat && !reg_wdata[`HCIS_BIT_FLAG_LSB + i]));
    end
  endgenerate

  // Pin latch sets only for enabled events and clears on a zero write.
  always_comb begin
    next_int_active = (|(evt & evt_en)) ||  // RULE_16
      (int_active && !(wr_stat && !reg_wdata[`HCIS_BIT_INT_ACTIVE]));  // RULE_12
  end

  // ========================================================================
  // Stage sequencer. The timer only runs in the configuration stage; a 23-bit
  // counter covers the default timeout at this clock rate.
  always_comb begin
    next_stage   = stage;
    next_touched = touched;
    next_tmr     = tmr;
    case (stage)
      HCIS_ST_CONFIG: begin
        next_tmr = tmr_done ? tmr : tmr + 23'h000001;
        if (wr_ilock) begin
          next_touched = 1'b1;
          if (!reg_wdata[`HCIS_BIT_CONFIG_N]) begin
            next_stage = HCIS_ST_CONNECT;  // RULE_07
          end
        end else if (touched) begin
          // Bit 0 set by the processor holds the stage indefinitely.
          if (!ilock[`HCIS_BIT_CONFIG_N]) begin  // RULE_06
            next_stage = HCIS_ST_CONNECT;
          end
        end else if (tmr_done) begin
          next_stage = HCIS_ST_CONNECT;  // RULE_08
        end
      end
      HCIS_ST_CONNECT: begin
        if (!ilock[`HCIS_BIT_CONNECT_N]) begin  // RULE_04
          next_stage = HCIS_ST_COMM;  // RULE_05
        end
      end
      HCIS_ST_COMM: begin
        next_stage = HCIS_ST_COMM;
      end
      default: begin
        next_stage = HCIS_ST_CONFIG;
      end
    endcase
  end

  // ========================================================================
  // Read data is registered; unmapped offsets read zero.
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      if (reg_hit(reg_addr, `HCIS_OFS_ILOCK)) begin
        next_rdata = ilock;
      end else if (reg_hit(reg_addr, `HCIS_OFS_STATUS)) begin
        next_rdata = {int_active, 2'b00, flag, 2'b00};  // RULE_11 RULE_18
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // ========================================================================
  // State registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ilock      <= `HCIS_ILOCK_RESET;  // RULE_01
      flag       <= '0;
      int_active <= 1'b0;
      stage      <= HCIS_ST_CONFIG;
      touched    <= 1'b0;
      tmr        <= 23'h000000;
      reg_rdata  <= 8'h00;
    end else begin
      ilock      <= next_ilock;
      flag       <= next_flag;
      int_active <= next_int_active;
      stage      <= next_stage;
      touched    <= next_touched;
      tmr        <= next_tmr;
      reg_rdata  <= next_rdata;
    end
  end

  // ========================================================================
  // Assertions.
  logic started;  // Low only in the first cycle after reset release.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence clr_bit0_wr;
    stage_config && wr_ilock && !reg_wdata[`HCIS_BIT_CONFIG_N];
  endsequence
  sequence susp_evt_s;
    suspend_event && suspend_event_enable;
  endsequence

  ilock_reset_a: assert property (!started |-> ilock == 8'h32)  // RULE_01
    else $error("interlock reset value wrong");
  oc_pin_sel_a: assert property (  // RULE_02
    (ilock[5] && !overcurrent_pin_n)[*5] |-> overcurrent_flag)
    else $error("over-current pin not honoured");
  pwr_pin_off_a: assert property (!ilock[4] |-> !port_power_pin_oe && !port_power_pin)  // RULE_03
    else $error("power pin driven while disabled");
  connect_hold_a: assert property (stage_connect && ilock[1] |=> stage_connect)  // RULE_04
    else $error("left connect stage early");
  connect_exit_a: assert property (stage_connect && !ilock[1] |=> stage_comm)  // RULE_05
    else $error("connect stage not left");
  config_hold_a: assert property (stage_config && touched && ilock[0] && !wr_ilock
    |=> stage_config)  // RULE_06
    else $error("left configuration stage early");
  config_exit_a: assert property (clr_bit0_wr |=> stage_connect)  // RULE_07
    else $error("configuration not left on clear");
  config_tout_a: assert property (stage_config && !touched && !wr_ilock && tmr_done
    |=> stage_connect)  // RULE_08
    else $error("timeout exit missing");
  int_pin_set_a: assert property (susp_evt_s |=> !int_n)  // RULE_11
    else $error("enabled event did not pull pin");
  int_release_a: assert property (wr_stat && !reg_wdata[7] && !(|(evt & evt_en))
    |=> int_n)  // RULE_12
    else $error("zero write did not release pin");
  susp_flag_a: assert property (  // RULE_13
    suspend_event |=> flag[2] ##1 (flag[2] || $past(wr_stat)))
    else $error("suspend flag not latched");
  setup_flag_a: assert property (host_setup_event |=> flag[1])  // RULE_14
    else $error("setup flag not latched");
  power_flag_a: assert property (flag[0] && !wr_stat |=> flag[0])  // RULE_15
    else $error("power flag lost");
  mask_gate_a: assert property (int_n && !(|(evt & evt_en)) |=> int_n)  // RULE_16
    else $error("pin asserted without enabled event");
  rsvd_zero_a: assert property ((ilock & 8'hCC) == 8'h00)  // RULE_18
    else $error("reserved interlock bits set");

endmodule

/* sim/hcis_host_model.sv */
/*
  Host processor model that reaches the interlock and status bank through
  the byte strobe port of the serial-port engine.
  Assumes the bank samples strobes on the rising edge of clk and answers a
  read with registered data one cycle later.
*/
module hcis_host_model (
  input  logic       clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_wr,
  output logic       reg_rd,
  input  logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Bus idle state.
  // Idle lines start at known values so the bank never sees an unknown.
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'hFF;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Drop the strobes and invert address and data, so a stale value is never
  // mistaken for a held one by a bank that samples too late.
  task automatic release_bus();
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  // ==========================================================================
  // Transfers.
  // One byte write; the request stands through the rising edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    @(negedge clk);
    release_bus();
  endtask

  // One byte read; the registered answer is settled by the following fall.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    @(negedge clk);
    d = reg_rdata;
    release_bus();
  endtask
endmodule

/* sim/hcis_top_tb_top.sv */
/*
  Self-checking bench of the stage interlock and event status bank.
  Assumes a short setup timeout parameter and a host model on the byte port.
*/
module hcis_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Signals.
  localparam int unsigned TMO = 20;  // Short timeout keeps the run brief.
  logic       clk, nrst;             // Clock and active-low reset.
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd;        // Strobes from the host model.
  logic [2:0] ev, ena;               // Events and enables: power, setup, suspend.
  logic       oc_pin_n, oc_reg, pwr_req;
  logic       oc_flag, pwr_pin, pwr_oe, int_n, st_cfg, st_con, st_com;
  logic [7:0] rv, il, r;             // Read value, interlock image, random byte.
  logic [15:0] seed;                 // Random generator state.
  int         bad_count, compares;   // Mismatch and comparison counters.

  hcis_top #(.SETUP_TIMEOUT_CYC(TMO)) i_hcis_top (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .suspend_event(ev[2]), .host_setup_event(ev[1]), .power_update_event(ev[0]),
    .suspend_event_enable(ena[2]), .host_setup_event_enable(ena[1]),
    .power_update_event_enable(ena[0]), .overcurrent_pin_n(oc_pin_n),
    .overcurrent_reg(oc_reg), .overcurrent_flag(oc_flag), .port_power_req(pwr_req),
    .port_power_pin(pwr_pin), .port_power_pin_oe(pwr_oe), .int_n(int_n),
    .stage_config(st_cfg), .stage_connect(st_con), .stage_comm(st_com));

  hcis_host_model i_hcis_host_model (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ==========================================================================
  // Helpers.
  // Fibonacci shift register; the seed makes every run identical.
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  // Expected over-current flag, power pin and its enable.
  function automatic logic [7:0] exp_pins(input logic [7:0] v, input logic pn, oc, rq);
    return {5'h00, v[5] ? ~pn : oc, v[4] & rq, v[4]};
  endfunction

  // Expected status after event i with its enable en.
  function automatic logic [7:0] exp_status(input int i, input logic en);
    return {en, 2'b00, 3'(1 << i), 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] stages();
    return {5'h00, st_com, st_con, st_cfg};
  endfunction

  // Reset is held for eight cycles and released off the sampling edge.
  task automatic do_reset();
    @(negedge clk);
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // The tests need well under a thousand cycles; this cuts a hang short.
  initial begin
    #(20 * 4000);
    bad_count++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    nrst = 1'b0;
    seed = 16'h24BD;
    ev = 3'h0;
    ena = 3'h0;
    oc_pin_n = 1'b1;
    oc_reg = 1'b0;
    pwr_req = 1'b0;
    do_reset();
    // Defaults, an unmapped read and the untouched timeout path.
    i_hcis_host_model.rd(8'hE7, rv);
    chk("interlock reset", rv, 8'h32);
    i_hcis_host_model.rd(8'hE8, rv);
    chk("status reset", rv, 8'h00);
    r = rnd();
    i_hcis_host_model.rd((r[7:1] == 7'h73) ? 8'h10 : r, rv);
    chk("unmapped read", rv, 8'h00);
    chk("stage early", stages(), 8'h01);
    // Release was six falls ago, so the stage must turn exactly at rise number TMO.
    repeat (TMO - 7) @(negedge clk);
    chk("stage before timeout", stages(), 8'h01);
    @(negedge clk);
    chk("stage after timeout", stages(), 8'h02);
    repeat (TMO) @(negedge clk);
    chk("connect held", stages(), 8'h02);
    i_hcis_host_model.wr(8'hE7, 8'h30);
    repeat (3) @(negedge clk);
    chk("comm stage", stages(), 8'h04);
    $display("test defaults and timeout done");
    // Configuration held by the host, then released by a write.
    do_reset();
    i_hcis_host_model.wr(8'hE7, 8'h33);
    repeat (TMO + 4) @(negedge clk);
    chk("config held", stages(), 8'h01);
    i_hcis_host_model.wr(8'hE7, 8'hFF);
    i_hcis_host_model.rd(8'hE7, rv);
    chk("interlock reserved", rv, 8'h33);
    i_hcis_host_model.wr(8'hE7, 8'h32);
    chk("config exit now", stages(), 8'h02);
    repeat (2) @(negedge clk);
    chk("config exit", stages(), 8'h02);
    i_hcis_host_model.wr(8'hE7, 8'h30);
    repeat (3) @(negedge clk);
    chk("comm after release", stages(), 8'h04);
    $display("test held configuration done");
    // Pin role selection for every pair of select bits with random pin levels.
    for (int k = 0; k < 8; k++) begin
      il = {2'b00, 2'(k), 4'h0};
      i_hcis_host_model.wr(8'hE7, il);
      r = rnd();
      oc_pin_n = r[0];
      oc_reg = r[1];
      pwr_req = r[2];
      repeat (6) @(negedge clk);
      chk("pin roles", {5'h00, oc_flag, pwr_pin, pwr_oe},
          exp_pins(il, r[0], r[1], r[2]));
    end
    $display("test pin roles done");
    // Each event with its enable low and high; one-writes, flag and pin clears.
    for (int i = 0; i < 3; i++) begin
      for (int en = 0; en < 2; en++) begin
        r = rnd();
        r[i] = en[0];
        @(negedge clk);
        ena = r[2:0];
        ev[i] = 1'b1;
        @(negedge clk);
        ev = 3'h0;
        chk("int pin", {7'h00, int_n}, {7'h00, ~en[0]});
        i_hcis_host_model.rd(8'hE8, rv);
        chk("status set", rv, exp_status(i, en[0]));
        i_hcis_host_model.wr(8'hE8, 8'hFF);
        i_hcis_host_model.rd(8'hE8, rv);
        chk("status one write", rv, exp_status(i, en[0]));
        i_hcis_host_model.wr(8'hE8, ~(8'h04 << i));
        i_hcis_host_model.rd(8'hE8, rv);
        chk("flag clear", rv, {en[0], 7'h00});
        chk("pin kept", {7'h00, int_n}, {7'h00, ~en[0]});
        i_hcis_host_model.wr(8'hE8, 8'h7F);
        i_hcis_host_model.rd(8'hE8, rv);
        chk("status clear", rv, 8'h00);
        chk("pin released", {7'h00, int_n}, 8'h01);
      end
    end
    $display("test events done");
    stop_test();
  end
endmodule
